// ==== src/usrd_detect.sv ====
// Purpose: suspend and reset detection for the device end of a usb 2.0 link
// Assumes: bus activity strobes come from logic on this clock; line pins are asynchronous
// Notes: registers are reached over APB with zero wait states
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Function
// R1: full speed, 3 ms idle plus J held through the sample sets suspend flag
// R2: inactivity is declared strictly between 3.0 ms and 3.125 ms after activity
// R3: line is sampled 100 to 875 us after inactivity; J sets suspend flag
// R4: interrupt output goes low with the flag when all three enables are set
// R5: resume signalling is never driven before 5 ms of bus silence
// R6: firmware sets watch-off before sleep; full suspend by 10 ms
// R7: with full suspend and sleep requested, internal clock stops within 10 us
// R8: high speed, 3 ms idle switches to full-speed terminations before 3.125 ms
// R9: the switch writes 1 to both transceiver and termination speed selects
// R10: after high-speed fallback, SE0 at the sample point sets reset flag
// R11: full speed, SE0 held 2.5 us sets reset flag
// R12: firmware sets watch-off before starting the chirp handshake after reset
// R13: after high-speed fallback, J at the sample point sets suspend flag
// R14: bus activity restarts the idle timer; flags stay until firmware clears them
module usrd_detect
#(
    parameter logic [20:0] INACT_CYC = usrd_pkg::USRD_INACT_CYC,
    parameter logic [20:0] SAMPLE_CYC = usrd_pkg::USRD_SAMPLE_CYC,
    parameter logic [20:0] RESUME_CYC = usrd_pkg::USRD_RESUME_CYC,
    parameter logic [20:0] FULL_SUSP_CYC = usrd_pkg::USRD_FULL_SUSP_CYC
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus side
    input wire logic [1:0] busLineCondition,
    input wire logic txActive,
    input wire logic rxActive,
    // transceiver and power control
    output logic transceiverSpeedSel,
    output logic terminationSpeedSel,
    output logic resumeDrive,
    output logic internalClockOff,
    // interrupt
    output logic irq_n
);
    import usrd_pkg::*;

    usrd_state_e state_r, state_nxt;
    logic [20:0] idleCnt_r, idleCnt_nxt;
    logic [8:0] se0Cnt_r, se0Cnt_nxt;
    logic jHeld_r, jHeld_nxt;
    logic fellBack_r, fellBack_nxt;
    logic [1:0] lineS1_r, lineS2_r, lineS3_r, line_r, line_nxt;
    logic [1:0] flags_r, flags_nxt, flagSet;
    logic [1:0] engineEn_r, engineEn_nxt;
    logic deviceEn_r, deviceEn_nxt;
    logic topEn_r, topEn_nxt;
    logic [2:0] control_r, control_nxt;
    logic [1:0] xcvr_r, xcvr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic irq_n_r, irq_n_nxt;
    logic resume_r, resume_nxt;
    logic clkOff_r, clkOff_nxt;
    logic activity, watchOff, wrStrobe, setupRd, mapped;
    logic [31:0] rdMux;

    assign activity = txActive | rxActive;
    assign watchOff = control_r[USRD_B_WATCH_OFF];
    assign wrStrobe = psel & penable & pready_r & pwrite;
    assign setupRd = psel & ~penable;

    // line pins: three stages, a change is taken once stages two and three agree
    always_comb
    begin
        line_nxt = line_r;
        if (lineS2_r == lineS3_r)
        begin
            line_nxt = lineS3_r;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            lineS1_r <= USRD_LINE_J;
            lineS2_r <= USRD_LINE_J;
            lineS3_r <= USRD_LINE_J;
            line_r <= USRD_LINE_J;
        end
        else
        begin
            lineS1_r <= busLineCondition;
            lineS2_r <= lineS1_r;
            lineS3_r <= lineS2_r;
            line_r <= line_nxt;
        end
    end

    // apb decode and register file
    always_comb
    begin
        mapped = 1'b1;
        rdMux = 32'h0000_0000;
        unique case (paddr)
            USRD_OFS_STATUS: rdMux[1:0] = flags_r;
            USRD_OFS_ENGINE_EN: rdMux[1:0] = engineEn_r;
            USRD_OFS_DEVICE_EN: rdMux[0] = deviceEn_r;
            USRD_OFS_TOP_EN: rdMux[0] = topEn_r;
            USRD_OFS_CONTROL: rdMux[2:0] = control_r;
            USRD_OFS_XCVR: rdMux[1:0] = xcvr_r;
            USRD_OFS_LINE: rdMux[4:0] = {clkOff_r, resume_r, state_r != USRD_ST_WATCH, line_r};
            default: mapped = 1'b0;
        endcase
        pready_nxt = setupRd;
        pslverr_nxt = setupRd & ~mapped;
        prdata_nxt = (setupRd & ~pwrite) ? rdMux : 32'h0000_0000;
        engineEn_nxt = engineEn_r;
        deviceEn_nxt = deviceEn_r;
        topEn_nxt = topEn_r;
        control_nxt = control_r;
        if (wrStrobe && paddr == USRD_OFS_ENGINE_EN)
        begin
            engineEn_nxt = pwdata[1:0];
        end
        if (wrStrobe && paddr == USRD_OFS_DEVICE_EN)
        begin
            deviceEn_nxt = pwdata[0];
        end
        if (wrStrobe && paddr == USRD_OFS_TOP_EN)
        begin
            topEn_nxt = pwdata[0];
        end
        if (wrStrobe && paddr == USRD_OFS_CONTROL)
        begin
            control_nxt = pwdata[2:0];
        end
    end

    // detection engine
    always_comb
    begin
        state_nxt = state_r;
        jHeld_nxt = jHeld_r;
        fellBack_nxt = fellBack_r;
        flagSet = 2'h0;
        xcvr_nxt = xcvr_r;
        if (wrStrobe && paddr == USRD_OFS_XCVR)
        begin
            xcvr_nxt = pwdata[1:0];
        end
        idleCnt_nxt = idleCnt_r;
        if (activity)
        begin
            idleCnt_nxt = 21'h00_0000; // R14
        end
        else if (idleCnt_r < FULL_SUSP_CYC)
        begin
            idleCnt_nxt = idleCnt_r + 21'h00_0001;
        end
        unique case (state_r)
            USRD_ST_WATCH:
            begin
                if (idleCnt_r == INACT_CYC) // R2
                begin
                    state_nxt = USRD_ST_SAMPLE;
                    jHeld_nxt = (line_r == USRD_LINE_J);
                    if (!xcvr_r[USRD_B_XCVR_SEL])
                    begin
                        // high speed: drop to full-speed terminations and pull-up
                        fellBack_nxt = 1'b1; // R8
                        xcvr_nxt = 2'h3; // R9
                    end
                end
            end
            USRD_ST_SAMPLE:
            begin
                if (line_r != USRD_LINE_J)
                begin
                    jHeld_nxt = 1'b0; // R1
                end
                if (idleCnt_r == INACT_CYC + SAMPLE_CYC) // R3
                begin
                    state_nxt = USRD_ST_HOLD;
                    if (line_r == USRD_LINE_J && (jHeld_r || fellBack_r))
                    begin
                        flagSet[USRD_B_SUSPEND] = 1'b1; // R1 R13
                    end
                    else if (line_r == USRD_LINE_SE0 && fellBack_r)
                    begin
                        flagSet[USRD_B_RESET] = 1'b1; // R10
                    end
                end
            end
            USRD_ST_HOLD:
            begin
                state_nxt = USRD_ST_HOLD;
            end
            default:
            begin
                state_nxt = USRD_ST_WATCH;
            end
        endcase
        // full-speed reset: SE0 held long enough
        se0Cnt_nxt = 9'h000;
        if (!watchOff && !activity && fellBack_r == 1'b0 && xcvr_r[USRD_B_XCVR_SEL] && line_r == USRD_LINE_SE0)
        begin
            se0Cnt_nxt = (se0Cnt_r == USRD_SE0_CYC) ? se0Cnt_r : se0Cnt_r + 9'h001;
            if (se0Cnt_r == USRD_SE0_CYC - 9'h001)
            begin
                flagSet[USRD_B_RESET] = 1'b1; // R11
            end
        end
        if (activity || watchOff)
        begin
            // watch-off parks detection so firmware can run its own sequences
            state_nxt = USRD_ST_WATCH; // R14 R12 R6
            fellBack_nxt = 1'b0;
            flagSet = 2'h0;
        end
        flags_nxt = flags_r;
        if (wrStrobe && paddr == USRD_OFS_STATUS)
        begin
            flags_nxt = flags_r & ~pwdata[1:0];
        end
        // a hardware set in the clearing cycle wins
        flags_nxt = flags_nxt | flagSet; // R14
        irq_n_nxt = ~(|(flags_nxt & engineEn_nxt) & deviceEn_nxt & topEn_nxt); // R4
        resume_nxt = control_nxt[USRD_B_WAKEUP] & ~activity & (idleCnt_nxt >= RESUME_CYC); // R5
        // clock stop only once the bus has been quiet long enough and firmware parked detection
        clkOff_nxt = control_r[USRD_B_SLEEP] & watchOff & (idleCnt_r >= FULL_SUSP_CYC); // R7
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_r <= USRD_ST_WATCH;
            idleCnt_r <= 21'h00_0000;
            se0Cnt_r <= 9'h000;
            jHeld_r <= 1'b0;
            fellBack_r <= 1'b0;
            flags_r <= USRD_RST_FLAGS;
            engineEn_r <= 2'h0;
            deviceEn_r <= 1'b0;
            topEn_r <= 1'b0;
            control_r <= USRD_RST_CONTROL;
            xcvr_r <= USRD_RST_XCVR;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_n_r <= 1'b1;
            resume_r <= 1'b0;
            clkOff_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            idleCnt_r <= idleCnt_nxt;
            se0Cnt_r <= se0Cnt_nxt;
            jHeld_r <= jHeld_nxt;
            fellBack_r <= fellBack_nxt;
            flags_r <= flags_nxt;
            engineEn_r <= engineEn_nxt;
            deviceEn_r <= deviceEn_nxt;
            topEn_r <= topEn_nxt;
            control_r <= control_nxt;
            xcvr_r <= xcvr_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_n_r <= irq_n_nxt;
            resume_r <= resume_nxt;
            clkOff_r <= clkOff_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign transceiverSpeedSel = xcvr_r[USRD_B_XCVR_SEL];
    assign terminationSpeedSel = xcvr_r[USRD_B_TERM_SEL];
    assign resumeDrive = resume_r;
    assign internalClockOff = clkOff_r;
    assign irq_n = irq_n_r;

    // checks
    property p_irq_gating;
        @(posedge clock) disable iff (!rst_n)
        !irq_n_r == (|(flags_r & engineEn_r) & deviceEn_r & topEn_r);
    endproperty
    a_irq_gating: assert property (p_irq_gating) else $error("irq_n does not match gated flags"); // R4

    // shortened counts in a bench cannot sit in the millisecond window, so only the real count is held to it
    property p_inact_window;
        @(posedge clock) disable iff (!rst_n)
        (state_r == USRD_ST_WATCH && state_nxt == USRD_ST_SAMPLE)
            |-> idleCnt_r == INACT_CYC && (INACT_CYC != USRD_INACT_CYC
            || (INACT_CYC > USRD_INACT_MIN_CYC && INACT_CYC < USRD_INACT_MAX_CYC));
    endproperty
    a_inact_window: assert property (p_inact_window) else $error("inactivity declared at wrong count"); // R2

    sequence s_sample_j;
        state_r == USRD_ST_SAMPLE && idleCnt_r == INACT_CYC + SAMPLE_CYC && !activity && !watchOff
            && line_r == USRD_LINE_J && (jHeld_r || fellBack_r);
    endsequence
    property p_suspend_set;
        @(posedge clock) disable iff (!rst_n)
        s_sample_j |=> flags_r[USRD_B_SUSPEND] && state_r == USRD_ST_HOLD;
    endproperty
    a_suspend_set: assert property (p_suspend_set) else $error("suspend flag missed at sample point"); // R1 R3 R13

    property p_suspend_cause;
        @(posedge clock) disable iff (!rst_n)
        $rose(flags_r[USRD_B_SUSPEND]) |-> $past(idleCnt_r) == INACT_CYC + SAMPLE_CYC && $past(line_r) == USRD_LINE_J;
    endproperty
    a_suspend_cause: assert property (p_suspend_cause) else $error("suspend flag set off the sample point"); // R3

    property p_fallback;
        @(posedge clock) disable iff (!rst_n)
        (state_r == USRD_ST_WATCH && idleCnt_r == INACT_CYC && !activity && !watchOff && !xcvr_r[USRD_B_XCVR_SEL])
            |=> xcvr_r == 2'h3 && fellBack_r;
    endproperty
    a_fallback: assert property (p_fallback) else $error("high-speed fallback not made"); // R8 R9

    property p_hs_reset;
        @(posedge clock) disable iff (!rst_n)
        ($rose(flags_r[USRD_B_RESET]) && $past(fellBack_r))
            |-> $past(line_r) == USRD_LINE_SE0 && $past(idleCnt_r) == INACT_CYC + SAMPLE_CYC;
    endproperty
    a_hs_reset: assert property (p_hs_reset) else $error("high-speed reset flag set wrongly"); // R10

    property p_fs_reset;
        @(posedge clock) disable iff (!rst_n)
        ($rose(flags_r[USRD_B_RESET]) && !$past(fellBack_r)) |-> $past(se0Cnt_r) == USRD_SE0_CYC - 9'h001;
    endproperty
    a_fs_reset: assert property (p_fs_reset) else $error("full-speed reset flag set before SE0 time"); // R11

    property p_resume_late;
        @(posedge clock) disable iff (!rst_n)
        resume_r |-> idleCnt_r >= RESUME_CYC;
    endproperty
    a_resume_late: assert property (p_resume_late) else $error("resume driven too early"); // R5

    property p_clock_stop;
        @(posedge clock) disable iff (!rst_n)
        (control_r[USRD_B_SLEEP] && watchOff && idleCnt_r >= FULL_SUSP_CYC) |-> ##[1:2] clkOff_r;
    endproperty
    a_clock_stop: assert property (p_clock_stop) else $error("internal clock not stopped in time"); // R7

    property p_restart;
        @(posedge clock) disable iff (!rst_n)
        activity |=> idleCnt_r == 21'h00_0000 && state_r == USRD_ST_WATCH;
    endproperty
    a_restart: assert property (p_restart) else $error("activity did not restart idle timer"); // R14

    property p_sticky;
        @(posedge clock) disable iff (!rst_n)
        (flags_r[USRD_B_SUSPEND] && !(wrStrobe && paddr == USRD_OFS_STATUS)) |=> flags_r[USRD_B_SUSPEND];
    endproperty
    a_sticky: assert property (p_sticky) else $error("suspend flag dropped without clear"); // R14

endmodule : usrd_detect

// ==== src/usrd_pkg.sv ====
// Purpose: shared constants for the usb suspend/reset bus-event detector
// Assumes: 125 MHz clock, APB register access with 32-bit data
// Notes: times are kept in their own unit, cycle counts derive from them
package usrd_pkg;

    // clock
    localparam int USRD_CLK_MHZ = 125;

    // times as chosen inside the documented windows
    localparam int USRD_INACT_US = 3050;
    localparam int USRD_SAMPLE_US = 400;
    localparam int USRD_RESUME_US = 5000;
    localparam int USRD_FULL_SUSP_US = 10000;
    localparam int USRD_SE0_NS = 2500;
    localparam int USRD_INACT_MIN_US = 3000;
    localparam int USRD_INACT_MAX_NS = 3125000;

    // cycle counts; a least time rounds up
    localparam logic [20:0] USRD_INACT_CYC = 21'(USRD_INACT_US * USRD_CLK_MHZ);
    localparam logic [20:0] USRD_SAMPLE_CYC = 21'(USRD_SAMPLE_US * USRD_CLK_MHZ);
    localparam logic [20:0] USRD_RESUME_CYC = 21'(USRD_RESUME_US * USRD_CLK_MHZ);
    localparam logic [20:0] USRD_FULL_SUSP_CYC = 21'(USRD_FULL_SUSP_US * USRD_CLK_MHZ);
    localparam logic [8:0] USRD_SE0_CYC = 9'((USRD_SE0_NS * USRD_CLK_MHZ + 999) / 1000);
    localparam logic [20:0] USRD_INACT_MIN_CYC = 21'(USRD_INACT_MIN_US * USRD_CLK_MHZ);
    localparam logic [20:0] USRD_INACT_MAX_CYC = 21'(USRD_INACT_MAX_NS / 1000 * USRD_CLK_MHZ);

    // register byte offsets
    localparam logic [7:0] USRD_OFS_STATUS = 8'h00;
    localparam logic [7:0] USRD_OFS_ENGINE_EN = 8'h04;
    localparam logic [7:0] USRD_OFS_DEVICE_EN = 8'h08;
    localparam logic [7:0] USRD_OFS_TOP_EN = 8'h0C;
    localparam logic [7:0] USRD_OFS_CONTROL = 8'h10;
    localparam logic [7:0] USRD_OFS_XCVR = 8'h14;
    localparam logic [7:0] USRD_OFS_LINE = 8'h18;

    // field positions
    localparam int USRD_B_SUSPEND = 0;
    localparam int USRD_B_RESET = 1;
    localparam int USRD_B_WATCH_OFF = 0;
    localparam int USRD_B_SLEEP = 1;
    localparam int USRD_B_WAKEUP = 2;
    localparam int USRD_B_XCVR_SEL = 0;
    localparam int USRD_B_TERM_SEL = 1;

    // reset values
    localparam logic [1:0] USRD_RST_FLAGS = 2'h0;
    localparam logic [2:0] USRD_RST_CONTROL = 3'h0;
    localparam logic [1:0] USRD_RST_XCVR = 2'h3;

    // line condition codes
    localparam logic [1:0] USRD_LINE_SE0 = 2'h0;
    localparam logic [1:0] USRD_LINE_J = 2'h1;

    typedef enum logic [2:0]
    {
        USRD_ST_WATCH = 3'h1,
        USRD_ST_SAMPLE = 3'h2,
        USRD_ST_HOLD = 3'h4
    } usrd_state_e;

endpackage : usrd_pkg

// ==== testbench/tb_usb_suspend_reset_detect.sv ====
// Purpose: self-checking bench for the suspend and reset detector
// Assumes: shortened idle counts 100/40/200/400 cycles; apb answers after one wait-free access
// Notes: timings are counted from the edge that saw the last bus activity
`timescale 1ns/1ps
module tb_usb_suspend_reset_detect;
    import usrd_pkg::*;
    localparam logic [1:0] LINE_K = 2'h2;
    logic clock, rst_n, psel, penable, pwrite, pready, pslverr, txActive, rxActive;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] busLineCondition;
    logic transceiverSpeedSel, terminationSpeedSel, resumeDrive, internalClockOff, irq_n;
    int nFail = 0;
    int checksDone = 0;

    usrd_detect #(.INACT_CYC(21'h0_0064), .SAMPLE_CYC(21'h0_0028), .RESUME_CYC(21'h0_00C8),
        .FULL_SUSP_CYC(21'h0_0190)) dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .busLineCondition(busLineCondition), .txActive(txActive), .rxActive(rxActive),
        .transceiverSpeedSel(transceiverSpeedSel), .terminationSpeedSel(terminationSpeedSel),
        .resumeDrive(resumeDrive), .internalClockOff(internalClockOff), .irq_n(irq_n));

    usrd_host_model host (.clock(clock), .busLineCondition(busLineCondition), .rxActive(rxActive));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            nFail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic got, input logic exp);
        chk_reg({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : chk_pin

    // ends one edge after release so the next request never lands in the same step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        chk_pin(pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    // extra edge lets registered outputs settle on the new register value
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
        @(posedge clock);
    endtask : wr

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0000_0000, rd, e);
        chk_reg(rd, exp);
        chk_pin(e, experr);
    endtask : expect_reg

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask : idle

    task automatic giveVerdict();
        $display("comparisons %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : giveVerdict

    initial
    begin
        idle(10000);
        nFail++;
        giveVerdict();
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        txActive = 1'b0;
        idle(3);
        rst_n <= 1'b1;
        idle(1);
        chk_pin(irq_n, 1'b1);
        chk_pin(transceiverSpeedSel & terminationSpeedSel, 1'b1);
        chk_pin(resumeDrive | internalClockOff, 1'b0);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        expect_reg(USRD_OFS_CONTROL, 32'h0000_0000);
        expect_reg(USRD_OFS_XCVR, 32'h0000_0003);
        expect_reg(8'h1C, 32'h0000_0000, 1'b1);
        $display("test reset_and_map finished");

        wr(USRD_OFS_ENGINE_EN, 32'h0000_0003);
        wr(USRD_OFS_DEVICE_EN, 32'h0000_0001);
        wr(USRD_OFS_TOP_EN, 32'h0000_0001);
        wr(USRD_OFS_CONTROL, 32'h0000_0004);
        host.bus_event(USRD_LINE_J);
        idle(80);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        txActive <= 1'b1;
        idle(1);
        txActive <= 1'b0;
        idle(116);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        idle(30);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0001);
        chk_pin(irq_n, 1'b0);
        wr(USRD_OFS_TOP_EN, 32'h0000_0000);
        chk_pin(irq_n, 1'b1);
        wr(USRD_OFS_TOP_EN, 32'h0000_0001);
        chk_pin(irq_n, 1'b0);
        chk_pin(resumeDrive, 1'b0);
        idle(50);
        chk_pin(resumeDrive, 1'b1);
        wr(USRD_OFS_STATUS, 32'h0000_0001);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        chk_pin(irq_n, 1'b1);
        wr(USRD_OFS_CONTROL, 32'h0000_0003);
        chk_pin(internalClockOff, 1'b0);
        idle(190);
        chk_pin(internalClockOff, 1'b1);
        wr(USRD_OFS_CONTROL, 32'h0000_0001);
        host.bus_event(USRD_LINE_J);
        idle(160);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        wr(USRD_OFS_CONTROL, 32'h0000_0000);
        $display("test fs_suspend finished");

        host.bus_event(USRD_LINE_SE0);
        idle(290);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        idle(30);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0002);
        chk_pin(irq_n, 1'b0);
        wr(USRD_OFS_CONTROL, 32'h0000_0001);
        wr(USRD_OFS_STATUS, 32'h0000_0002);
        host.bus_event(USRD_LINE_J);
        wr(USRD_OFS_CONTROL, 32'h0000_0000);
        $display("test fs_reset finished");

        wr(USRD_OFS_XCVR, 32'h0000_0000);
        host.bus_event(USRD_LINE_SE0);
        idle(90);
        chk_pin(transceiverSpeedSel | terminationSpeedSel, 1'b0);
        idle(20);
        chk_pin(transceiverSpeedSel & terminationSpeedSel, 1'b1);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        idle(35);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0002);
        wr(USRD_OFS_STATUS, 32'h0000_0003);
        wr(USRD_OFS_XCVR, 32'h0000_0000);
        host.bus_event(USRD_LINE_J);
        idle(150);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0001);
        expect_reg(USRD_OFS_XCVR, 32'h0000_0003);
        $display("test hs_fallback finished");

        // full speed: a K blip inside the sample window must spoil the suspend decision
        wr(USRD_OFS_STATUS, 32'h0000_0001);
        host.bus_event(USRD_LINE_J);
        idle(110);
        host.line_to(LINE_K);
        idle(10);
        host.line_to(USRD_LINE_J);
        idle(50);
        expect_reg(USRD_OFS_STATUS, 32'h0000_0000);
        expect_reg(USRD_OFS_LINE, 32'h0000_0005);
        $display("test broken_j finished");
        giveVerdict();
    end
endmodule : tb_usb_suspend_reset_detect

// ==== testbench/usrd_host_model.sv ====
// Purpose: upstream port model driving the line condition and receive activity
// Assumes: line codes from usrd_pkg; every change lands just after a rising edge
// Notes: the line rests at the level the last bus_event or line_to gave it, and at J before the first one
`timescale 1ns/1ps
module usrd_host_model
(
    // clock
    input wire logic clock,
    // bus
    output logic [1:0] busLineCondition,
    output logic rxActive
);
    import usrd_pkg::*;

    initial
    begin
        busLineCondition = USRD_LINE_J;
        rxActive = 1'b0;
    end

    // one packet of activity, then the line rests at lvl with no more traffic
    task automatic bus_event(input logic [1:0] lvl);
        @(posedge clock);
        busLineCondition <= lvl;
        rxActive <= 1'b1;
        @(posedge clock);
        rxActive <= 1'b0;
    endtask : bus_event

    // line moves with no packet traffic, so the idle timer keeps running
    task automatic line_to(input logic [1:0] lvl);
        @(posedge clock);
        busLineCondition <= lvl;
    endtask : line_to
endmodule : usrd_host_model
